// [hdl/hsh_defines.svh]
// Purpose: Constants for the hard stop homing sequencer
// Assumes: 125 MHz drive clock
// Notes:   Velocity in units of 0.0042 rps, accel/decel in 0.167 rps/s
`ifndef HSH_DEFINES_SVH
`define HSH_DEFINES_SVH

`define HSH_VEL_W          15
`define HSH_RATE_W         15
`define HSH_CUR_W          12
`define HSH_VEL_MIN        15'h0001
`define HSH_VEL_MAX        15'h4A67
// 10 rps, 5 rps, 0.5 rps in 0.0042 rps units
`define HSH_VEL1_RST       15'h094D
`define HSH_VEL2_RST       15'h04A6
`define HSH_VEL3_RST       15'h0077
// 100, 100, 10 rps/s in 0.167 rps/s units
`define HSH_ACC1_RST       15'h0257
`define HSH_ACC2_RST       15'h0257
`define HSH_ACC3_RST       15'h003C
`define HSH_OFFSET_RST     32'h000007D0
`define HSH_CUR_RST        12'h064
`define HSH_CMD_START      3'h0
`define HSH_CMD_VEL        3'h1
`define HSH_CMD_ACC        3'h2
`define HSH_CMD_DEC        3'h3
`define HSH_CMD_CUR        3'h4
`define HSH_CMD_OFS        3'h5
`define HSH_CMD_QVEL       3'h6

`endif

// [hdl/hsh_pkg.sv]
// Purpose: Types for the hard stop homing sequencer
// Assumes: hsh_defines.svh widths
// Notes:   Command word is one queued entry from the host parser
`include "hsh_defines.svh"
package hsh_pkg;

    typedef struct packed {
        logic [2:0]  op;
        logic [1:0]  step;
        logic [31:0] arg;
    } hsh_cmd_t;

    typedef struct packed {
        logic                    active;
        logic                    dir_ccw;
        logic [`HSH_VEL_W-1:0]   vel;
        logic [`HSH_RATE_W-1:0]  accel;
        logic [`HSH_RATE_W-1:0]  decel;
        logic                    offset_move;
        logic [31:0]             distance;
    } hsh_motion_t;

    typedef struct packed {
        logic [1:0]              step;
        logic [`HSH_VEL_W-1:0]   vel;
    } hsh_vel_reply_t;

    typedef enum logic [2:0] {
        HSH_IDLE, HSH_SEEK_STOP, HSH_SETTLE, HSH_SEEK_INDEX, HSH_OFFSET, HSH_WAIT_DONE
    } hsh_state_t;

endpackage : hsh_pkg

// [hdl/hsh_sequencer.sv]
// Purpose: Hard stop homing sequencer with queued commands
// Assumes: Motion profile generator outside; current sample is in-domain
// Notes:   Index pulse arrives from a pin and is synchronised
`timescale 1ns/1ps
`include "hsh_defines.svh"
module hsh_sequencer (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire hsh_pkg::hsh_cmd_t        cmd,
    input  wire logic                     cmd_valid,
    output logic                          cmd_ready,
    input  wire logic [`HSH_CUR_W-1:0]    motor_current,
    input  wire logic                     index_pin,
    input  wire logic                     move_done,
    output hsh_pkg::hsh_motion_t          motion,
    output hsh_pkg::hsh_vel_reply_t       vel_reply,
    output logic                          vel_reply_valid,
    output logic                          homing_busy,
    output logic                          homed
);
    hsh_pkg::hsh_state_t     state_q, state_d;
    hsh_pkg::hsh_motion_t    motion_q, motion_d;
    logic                    use_index_q;
    logic [31:0]             offset_q;
    logic [`HSH_CUR_W-1:0]   cur_thr_q;
    logic                    idx_s1_q, idx_s2_q, idx_s3_q;
    logic                    homed_q;
    hsh_pkg::hsh_vel_reply_t reply_q;
    logic                    reply_v_q;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic take;
    logic is_start, wr_vel, wr_acc, wr_dec, wr_cur, wr_ofs, q_vel;
    assign cmd_ready = (state_q == hsh_pkg::HSH_IDLE);
    assign take      = cmd_valid && cmd_ready;
    assign is_start  = take && (cmd.op == `HSH_CMD_START);
    assign wr_vel    = take && (cmd.op == `HSH_CMD_VEL);
    assign wr_acc    = take && (cmd.op == `HSH_CMD_ACC);
    assign wr_dec    = take && (cmd.op == `HSH_CMD_DEC);
    assign wr_cur    = take && (cmd.op == `HSH_CMD_CUR);
    assign wr_ofs    = take && (cmd.op == `HSH_CMD_OFS);
    assign q_vel     = take && (cmd.op == `HSH_CMD_QVEL) && (cmd.step != 2'h0);

    // ------------------------------------------------------------
    // Per-step tables
    // ------------------------------------------------------------
    logic [1:0]              sel;
    logic [`HSH_VEL_W-1:0]   vel_rd;
    logic [`HSH_RATE_W-1:0]  acc_rd, dec_rd;
    logic [1:0]              vel_sel;

    // Step used by the motion stage currently being set up
    assign sel = (state_d == hsh_pkg::HSH_SEEK_STOP)  ? 2'h1 :
                 (state_d == hsh_pkg::HSH_OFFSET)     ? 2'h2 :
                 (state_d == hsh_pkg::HSH_WAIT_DONE)  ? 2'h2 :
                 (state_d == hsh_pkg::HSH_SEEK_INDEX) ? 2'h3 : 2'h1;
    assign vel_sel = q_vel ? cmd.step : sel;

    hsh_step_table #(.W(`HSH_VEL_W), .RV1(`HSH_VEL1_RST), .RV2(`HSH_VEL2_RST),
                     .RV3(`HSH_VEL3_RST), .MIN(`HSH_VEL_MIN), .MAX(`HSH_VEL_MAX)) u_vel (
        .clk   (clk),
        .rst   (rst),
        .wr    (wr_vel),
        .step  (cmd.step),
        .wdata (cmd.arg[`HSH_VEL_W-1:0]),
        .rsel  (vel_sel),
        .rdata (vel_rd)
    );
    hsh_step_table #(.W(`HSH_RATE_W), .RV1(`HSH_ACC1_RST), .RV2(`HSH_ACC2_RST),
                     .RV3(`HSH_ACC3_RST), .MIN(15'h0001)) u_acc (
        .clk   (clk),
        .rst   (rst),
        .wr    (wr_acc),
        .step  (cmd.step),
        .wdata (cmd.arg[`HSH_RATE_W-1:0]),
        .rsel  (sel),
        .rdata (acc_rd)
    );
    hsh_step_table #(.W(`HSH_RATE_W), .RV1(`HSH_ACC1_RST), .RV2(`HSH_ACC2_RST),
                     .RV3(`HSH_ACC3_RST), .MIN(15'h0001)) u_dec (
        .clk   (clk),
        .rst   (rst),
        .wr    (wr_dec),
        .step  (cmd.step),
        .wdata (cmd.arg[`HSH_RATE_W-1:0]),
        .rsel  (sel),
        .rdata (dec_rd)
    );

    // ------------------------------------------------------------
    // Index synchroniser and edge
    // ------------------------------------------------------------
    logic index_rise;
    logic stop_hit;
    assign index_rise = idx_s2_q && !idx_s3_q;
    assign stop_hit   = (motor_current >= cur_thr_q);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_d  = state_q;
        motion_d = motion_q;
        unique case (state_q)
            hsh_pkg::HSH_IDLE:
            begin
                if (is_start)
                begin
                    state_d              = hsh_pkg::HSH_SEEK_STOP;
                    motion_d.dir_ccw     = offset_q[31];
                    motion_d.offset_move = 1'b0;
                    motion_d.distance    = 32'h00000000;
                end
            end
            hsh_pkg::HSH_SEEK_STOP:
            begin
                // Stop is declared on current alone; the decel ramp then runs into the stop
                if (stop_hit)
                begin
                    state_d = hsh_pkg::HSH_SETTLE;
                end
            end
            hsh_pkg::HSH_SETTLE:
            begin
                motion_d.distance    = offset_q;
                if (use_index_q)
                begin
                    state_d              = hsh_pkg::HSH_SEEK_INDEX;
                    motion_d.dir_ccw     = !offset_q[31];
                    motion_d.offset_move = 1'b0;
                end
                else
                begin
                    state_d              = hsh_pkg::HSH_OFFSET;
                    motion_d.dir_ccw     = !offset_q[31];
                    motion_d.offset_move = 1'b1;
                end
            end
            hsh_pkg::HSH_SEEK_INDEX:
            begin
                if (index_rise)
                begin
                    state_d              = hsh_pkg::HSH_OFFSET;
                    motion_d.offset_move = 1'b1;
                end
            end
            hsh_pkg::HSH_OFFSET:
            begin
                // Give the profile generator one cycle to drop its done flag
                state_d = hsh_pkg::HSH_WAIT_DONE;
            end
            hsh_pkg::HSH_WAIT_DONE:
            begin
                if (move_done)
                begin
                    state_d = hsh_pkg::HSH_IDLE;
                end
            end
        endcase
        motion_d.active = (state_d != hsh_pkg::HSH_IDLE) && (state_d != hsh_pkg::HSH_SETTLE);
        if (state_d != state_q)
        begin
            motion_d.vel   = vel_rd;
            motion_d.accel = acc_rd;
            motion_d.decel = dec_rd;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q  <= hsh_pkg::HSH_IDLE;
            motion_q <= '0;
        end
        else
        begin
            state_q  <= state_d;
            motion_q <= motion_d;
        end
    end

    always_ff @(posedge clk)
    begin
        idx_s1_q <= index_pin;
        idx_s2_q <= idx_s1_q;
        idx_s3_q <= idx_s2_q;
    end

    // ------------------------------------------------------------
    // Settings and replies
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            use_index_q <= 1'b0;
            offset_q    <= `HSH_OFFSET_RST;
            cur_thr_q   <= `HSH_CUR_RST;
            homed_q     <= 1'b0;
            reply_q     <= '0;
            reply_v_q   <= 1'b0;
        end
        else
        begin
            if (is_start)
            begin
                use_index_q <= cmd.arg[0];
                homed_q     <= 1'b0;
            end
            if (wr_ofs)
            begin
                offset_q <= cmd.arg;
            end
            if (wr_cur)
            begin
                cur_thr_q <= cmd.arg[`HSH_CUR_W-1:0];
            end
            if ((state_q == hsh_pkg::HSH_WAIT_DONE) && move_done)
            begin
                homed_q <= 1'b1;
            end
            reply_v_q <= q_vel;
            if (q_vel)
            begin
                reply_q.step <= cmd.step;
                reply_q.vel  <= vel_rd;
            end
        end
    end

    assign motion          = motion_q;
    assign vel_reply       = reply_q;
    assign vel_reply_valid = reply_v_q;
    assign homing_busy     = (state_q != hsh_pkg::HSH_IDLE);
    assign homed           = homed_q;
endmodule : hsh_sequencer

// [hdl/hsh_step_table.sv]
// Purpose: Three-entry per-step parameter table
// Assumes: Step index 1..3; writes to step 0 ignored, a read of 0 gives step 1
// Notes:   Used for velocity, accel and decel
`timescale 1ns/1ps
module hsh_step_table #(
    parameter int           W   = 15,
    parameter logic [W-1:0] RV1 = '0,
    parameter logic [W-1:0] RV2 = '0,
    parameter logic [W-1:0] RV3 = '0,
    parameter logic [W-1:0] MIN = '0,
    parameter logic [W-1:0] MAX = '1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         wr,
    input  wire logic [1:0]   step,
    input  wire logic [W-1:0] wdata,
    input  wire logic [1:0]   rsel,
    output logic      [W-1:0] rdata
);
    logic [W-1:0] v_q [1:3];
    logic [W-1:0] clamped;
    logic         step_ok;

    // Out-of-range values are clamped rather than refused, so the table always holds a legal value
    assign clamped = (wdata < MIN) ? MIN : ((wdata > MAX) ? MAX : wdata);
    assign step_ok = (step != 2'h0);
    assign rdata   = (rsel == 2'h0) ? v_q[1] : v_q[rsel];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            v_q[1] <= RV1;
            v_q[2] <= RV2;
            v_q[3] <= RV3;
        end
        else if (wr && step_ok)
        begin
            v_q[step] <= clamped;
        end
    end
endmodule : hsh_step_table

// [tb/hsh_motor_model.sv]
// Purpose: Motor with rigid end stop and encoder index
// Assumes: Current reaches the threshold once the stop is hit
// Notes:   dly sets how soon each event comes: prompt or slow
`timescale 1ns/1ps
module hsh_motor_model (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire hsh_pkg::hsh_motion_t motion,
    input  wire logic [11:0]          thr,
    input  wire logic [7:0]           dly,
    output logic      [11:0]          motor_current,
    output logic                      index_pin,
    output logic                      move_done
);
    hsh_pkg::hsh_motion_t prev_q;
    logic [7:0]           cnt_q;
    logic                 hit_q;
    // Count only once a new command has stood a full cycle, so a stale idle count never fires early
    wire                  due = motion.active && motion == prev_q && cnt_q >= dly;

    always_ff @(posedge clk)
    begin
        prev_q <= motion;
        cnt_q  <= (rst || motion != prev_q) ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hFF};
        hit_q  <= !rst && !motion.offset_move && (hit_q || motor_current >= thr);
    end

    // One count short of the threshold so a > versus >= slip shows
    assign motor_current = (due && !hit_q && !motion.offset_move) ? thr : thr - 12'h001;
    assign index_pin     = due && hit_q && !motion.offset_move;
    assign move_done     = due && motion.offset_move;
endmodule : hsh_motor_model

// [tb/hsh_sequencer_asserts.sv]
// Purpose: Port checks of the homing sequencer
// Assumes: Velocity writes stay within 15 bits
// Notes:   Shadows the velocity, offset, threshold and index settings taken on the command port
`timescale 1ns/1ps
`include "hsh_defines.svh"
module hsh_sequencer_asserts (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire hsh_pkg::hsh_cmd_t       cmd,
    input wire logic                    cmd_valid,
    input wire logic                    cmd_ready,
    input wire logic [`HSH_CUR_W-1:0]   motor_current,
    input wire logic                    index_pin,
    input wire logic                    move_done,
    input wire hsh_pkg::hsh_motion_t    motion,
    input wire hsh_pkg::hsh_vel_reply_t vel_reply,
    input wire logic                    vel_reply_valid,
    input wire logic                    homing_busy,
    input wire logic                    homed
);
    wire         take  = cmd_valid && cmd_ready;
    wire         start = take && cmd.op == `HSH_CMD_START;
    wire [14:0]  vel_w = (cmd.arg > 32'h00004A67) ? `HSH_VEL_MAX : (cmd.arg == 32'h0) ? `HSH_VEL_MIN : cmd.arg[14:0];
    logic [14:0] vel_q [0:3];
    logic [31:0] ofs_q;
    logic [11:0] thr_q;
    logic        opt_q;
    logic        seek_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            vel_q  <= '{15'h0000, `HSH_VEL1_RST, `HSH_VEL2_RST, `HSH_VEL3_RST};
            ofs_q  <= `HSH_OFFSET_RST;
            thr_q  <= `HSH_CUR_RST;
            opt_q  <= 1'b0;
            seek_q <= 1'b0;
        end
        else
        begin
            if (take && cmd.op == `HSH_CMD_VEL && cmd.step != 2'h0) vel_q[cmd.step] <= vel_w;
            if (take && cmd.op == `HSH_CMD_OFS) ofs_q <= cmd.arg;
            if (take && cmd.op == `HSH_CMD_CUR) thr_q <= cmd.arg[11:0];
            if (start) opt_q <= cmd.arg[0];
            seek_q <= start || (seek_q && !(motion.active && motor_current >= thr_q));
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    busy_ready_a: assert property (homing_busy |-> !cmd_ready)
        else $error("command taken while busy");
    dir_sign_a: assert property (start |=> motion.active && motion.dir_ccw == ofs_q[31])
        else $error("wrong start direction");
    stop_vel_a: assert property (start |=> motion.vel == vel_q[1])
        else $error("wrong stop search speed");
    stop_detect_a: assert property (seek_q && motion.active && motor_current >= thr_q |=> !motion.active)
        else $error("end stop missed");
    index_vel_a: assert property ($rose(motion.active) && !seek_q |-> (opt_q ? (!motion.offset_move && motion.vel == vel_q[3]) : motion.offset_move))
        else $error("wrong index search");
    offset_hold_a: assert property (motion.active && motion.offset_move |-> motion.vel == vel_q[2] && motion.distance == ofs_q)
        else $error("offset move speed or distance changed");
    offset_move_a: assert property ($rose(motion.offset_move) |-> motion.vel == vel_q[2] && motion.distance == ofs_q)
        else $error("wrong offset move");
    done_homed_a: assert property (motion.offset_move && move_done |-> ##[1:3] homed && !homing_busy)
        else $error("homing not finished");
    reply_val_a: assert property (take && cmd.op == `HSH_CMD_QVEL && cmd.step != 2'h0 |=>
        vel_reply_valid && vel_reply.step == $past(cmd.step) && vel_reply.vel == vel_q[$past(cmd.step)])
        else $error("wrong velocity reply");

    cover property (start && cmd.arg[0]);
    cover property (start && !cmd.arg[0]);
    cover property ($rose(homed));
endmodule : hsh_sequencer_asserts

bind hsh_sequencer hsh_sequencer_asserts u_chk (
    .clk(clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .motor_current(motor_current), .index_pin(index_pin), .move_done(move_done), .motion(motion),
    .vel_reply(vel_reply), .vel_reply_valid(vel_reply_valid), .homing_busy(homing_busy), .homed(homed)
);

// [tb/hsh_sequencer_tb_top.sv]
// Purpose: Self-checking bench for the homing sequencer
// Assumes: Inputs change 1 ns after each rising edge
// Notes:   Motor model answers promptly or slowly per run
`timescale 1ns/1ps
`include "hsh_defines.svh"
module hsh_sequencer_tb_top;
    logic                    clk       = 1'b0;
    logic                    rst       = 1'b1;
    hsh_pkg::hsh_cmd_t       cmd       = '0;
    logic                    cmd_valid = 1'b0;
    logic [7:0]              dly       = 8'h02;
    logic                    cmd_ready, index_pin, move_done, vel_reply_valid, homing_busy, homed;
    logic [11:0]             motor_current;
    hsh_pkg::hsh_motion_t    motion;
    hsh_pkg::hsh_vel_reply_t vel_reply;
    int                      bad_count = 0;
    int                      checked   = 0;

    always #4 clk = ~clk;

    hsh_sequencer DUT (
        .clk(clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .motor_current(motor_current), .index_pin(index_pin), .move_done(move_done), .motion(motion),
        .vel_reply(vel_reply), .vel_reply_valid(vel_reply_valid), .homing_busy(homing_busy), .homed(homed)
    );
    hsh_motor_model u_motor (
        .clk(clk), .rst(rst), .motion(motion), .thr(12'h200), .dly(dly),
        .motor_current(motor_current), .index_pin(index_pin), .move_done(move_done)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // An edge passes first, so valid never toggles twice in one step
    task automatic send(input logic [2:0] op, input logic [1:0] st, input logic [31:0] a);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        cmd       = '{op, st, a};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 5000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        if (n == 5000) chk(32'h0, 32'h1);
    endtask : send

    task automatic query(input logic [1:0] st, input logic [14:0] exp);
        send(`HSH_CMD_QVEL, st, 32'h0);
        chk({14'h0, vel_reply_valid, vel_reply}, {14'h0, 1'b1, st, exp});
    endtask : query

    // The query waits behind the homing run, then proves it held off
    task automatic home(input logic opt, input logic [31:0] ofs, input logic [14:0] v1);
        send(`HSH_CMD_OFS, 2'h0, ofs);
        send(`HSH_CMD_START, 2'h0, {31'h0, opt});
        chk({motion.active, motion.dir_ccw, homing_busy, cmd_ready, homed, 12'h0, motion.vel}, {1'b1, ofs[31], 3'b100, 12'h0, v1});
        chk({2'h0, motion.accel, motion.decel}, {2'h0, 15'h0100, 15'h0200});
        query(2'h1, v1);
        chk({31'h0, homed}, 32'h1);
    endtask : home

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        query(2'h1, `HSH_VEL1_RST);
        query(2'h2, `HSH_VEL2_RST);
        query(2'h3, `HSH_VEL3_RST);
        send(`HSH_CMD_VEL, 2'h3, 32'h0);
        query(2'h3, `HSH_VEL_MIN);
        send(`HSH_CMD_VEL, 2'h3, 32'h5000);
        query(2'h3, `HSH_VEL_MAX);
        send(`HSH_CMD_VEL, 2'h0, 32'h0123);
        query(2'h1, `HSH_VEL1_RST);
        send(`HSH_CMD_QVEL, 2'h0, 32'h0);
        chk({31'h0, vel_reply_valid}, 32'h0);
        send(`HSH_CMD_VEL, 2'h1, 32'h0200);
        send(`HSH_CMD_VEL, 2'h2, 32'h0321);
        send(`HSH_CMD_VEL, 2'h3, 32'h0045);
        query(2'h2, 15'h0321);
        send(`HSH_CMD_CUR, 2'h0, 32'h0200);
        send(`HSH_CMD_ACC, 2'h1, 32'h0100);
        send(`HSH_CMD_DEC, 2'h1, 32'h0200);
        send(`HSH_CMD_DEC, 2'h2, 32'h0300);
        home(1'b1, 32'hFFFFF000, 15'h0200);
        dly = 8'h28;
        home(1'b0, 32'h00000100, 15'h0200);
        print_verdict();
    end

    // About 160 times the expected run
    initial
    begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule : hsh_sequencer_tb_top
